// *** nvm_params.svh ***
// Offsets, field positions, codes and reset values of the NVM security block
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH
`define OFS_FLASH_DIV 16'h0100
`define OFS_FLASH_SEC 16'h0101
`define OFS_FLASH_TEST 16'h0102
`define OFS_FLASH_CFG 16'h0103
`define OFS_FLASH_PROT 16'h0104
`define OFS_FLASH_STAT 16'h0105
`define OFS_FLASH_CMD 16'h0106
`define OFS_FLASH_ADDR 16'h0108
`define OFS_FLASH_DATA 16'h010A
`define OFS_EE_DIV 16'h0110
`define OFS_EE_PROT 16'h0114
`define OFS_EE_STAT 16'h0115
`define OFS_EE_CMD 16'h0116
`define OFS_EE_ADDR 16'h0118
`define OFS_EE_DATA 16'h011A
`define REG_SPACE_END 16'h0400
`define ARRAY_BASE 16'h4000
`define KEY_BASE 16'hFF00
`define SECTOR_TOP 16'hFE00
`define SECTOR_MASK 16'hFE00
`define BIT_BLANK 2
`define BIT_ACC_ERR 4
`define BIT_PROT_VIOL 5
`define BIT_DONE 6
`define BIT_BUF_EMPTY 7
`define CFG_KEY_BIT 5
`define WRITE_ALL_BIT 4
`define CMD_ERASE_VERIFY 8'h05
`define CMD_PROGRAM 8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41
`define CMD_SECTOR_MODIFY 8'h60
`define PROT_OPEN 8'hFF
`define PROT_RESET 8'h00
`define SEC_UNSECURED 2'h2
`define KEYEN_ON 2'h2
`define KEY_BAD_LOW 16'h0000
`define KEY_BAD_HIGH 16'hFFFF
`endif

// *** nvm_pkg.sv ***
// Types shared by the NVM security block
package nvm_pkg;
  typedef enum logic {ENG_IDLE, ENG_BUSY} engine_state_e;
  typedef enum logic [1:0] {DBG_OFF, DBG_HW, DBG_FULL} debug_level_e;
endpackage

// *** nvm_cmd_engine.sv ***
// Command sequencer for one flash block or the EEPROM array
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_cmd_engine (
  input wire logic clk,
  input wire logic rstN,
  input wire logic ce,
  input wire logic massOnly,
  input wire logic [15:0] wrValue,
  input wire logic [15:0] addrValue,
  input wire logic wrStatus,
  input wire logic wrCommand,
  input wire logic wrProtect,
  input wire logic [1:0] wrAddrLane,
  input wire logic [1:0] wrDataLane,
  input wire logic memDone,
  input wire logic memBlank,
  output logic [7:0] status,
  output logic [7:0] command,
  output logic [7:0] protect,
  output logic [15:0] address,
  output logic [15:0] data,
  output logic memStart,
  output logic [15:0] memAddr
);
  nvm_pkg::engine_state_e state;
  logic bufEmpty, done, protViol, accErr, blank;
  logic launch, cmdLegal, protFault, go;

  // Codes the array understands
  function automatic logic isKnown(input logic [7:0] c);
    isKnown = (c == `CMD_ERASE_VERIFY) || (c == `CMD_PROGRAM) || (c == `CMD_SECTOR_ERASE) ||
      (c == `CMD_MASS_ERASE) || (c == `CMD_SECTOR_MODIFY);
  endfunction

  // Launch and its checks
  assign launch = wrStatus && wrValue[`BIT_BUF_EMPTY] && bufEmpty;
  assign cmdLegal = isKnown(command) && (!massOnly || command == `CMD_MASS_ERASE);
  assign protFault = (protect != `PROT_OPEN) && ((command == `CMD_MASS_ERASE) ||
    (command != `CMD_ERASE_VERIFY && address >= `SECTOR_TOP));
  assign go = launch && !accErr && !protViol && cmdLegal && !protFault;

  // Shared status layout
  always_comb begin
    status = 8'h00;
    status[`BIT_BLANK] = blank;
    status[`BIT_ACC_ERR] = accErr;
    status[`BIT_PROT_VIOL] = protViol;
    status[`BIT_DONE] = done;
    status[`BIT_BUF_EMPTY] = bufEmpty;
  end

  // Error flags; set beats clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      accErr <= 1'b0;
      protViol <= 1'b0;
    end else if (ce) begin
      accErr <= (launch && (accErr || protViol || !cmdLegal)) ||
        (accErr && !(wrStatus && wrValue[`BIT_ACC_ERR]));
      protViol <= (launch && !accErr && !protViol && cmdLegal && protFault) ||
        (protViol && !(wrStatus && wrValue[`BIT_PROT_VIOL]));
    end
  end

  // Start pulse out, completion back
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state <= nvm_pkg::ENG_IDLE;
      bufEmpty <= 1'b1;
      done <= 1'b1;
      blank <= 1'b0;
      memStart <= 1'b0;
      memAddr <= 16'h0000;
    end else if (ce) begin
      memStart <= 1'b0;
      case (state)
        nvm_pkg::ENG_IDLE: begin
          if (go) begin
            state <= nvm_pkg::ENG_BUSY;
            bufEmpty <= 1'b0;
            done <= 1'b0;
            blank <= 1'b0;
            memStart <= 1'b1;
            // Whole sector, key and vectors included
            memAddr <= (command == `CMD_SECTOR_ERASE) ? (address & `SECTOR_MASK) : address;
          end
        end
        nvm_pkg::ENG_BUSY: begin
          if (memDone) begin
            state <= nvm_pkg::ENG_IDLE;
            bufEmpty <= 1'b1;
            done <= 1'b1;
            blank <= (command == `CMD_ERASE_VERIFY) && memBlank;
          end
        end
        default: state <= nvm_pkg::ENG_IDLE;
      endcase
    end
  end

  // Command buffer frozen while a command runs; protect register writable at any time
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      command <= 8'h00;
      protect <= `PROT_RESET;
      address <= 16'h0000;
      data <= 16'h0000;
    end else if (ce) begin
      if (wrProtect) protect <= wrValue[7:0];
      if (bufEmpty) begin
        if (wrCommand) command <= wrValue[7:0];
        if (wrAddrLane[1]) address[15:8] <= addrValue[15:8];
        if (wrAddrLane[0]) address[7:0] <= addrValue[7:0];
        if (wrDataLane[1]) data[15:8] <= wrValue[15:8];
        if (wrDataLane[0]) data[7:0] <= wrValue[7:0];
      end
    end
  end
endmodule // nvm_cmd_engine

// *** nvm_security_unsecure.sv ***
// Flash and EEPROM security, backdoor unlock and command register front end
// Functional notes
// - Any key word mismatch keeps the part secured.
// - Sector erase of top sector clears keys and vectors.
// - Security byte erase or program refused while its sector is protected.
// - Programmed security encoding takes effect at next reset.
// - Special modes: full EEPROM and flash erase lets part unsecure.
// - Secured special reset, memory not blank: hardware debug only.
// - Hardware debug may write NVM registers to launch mass erase.
// - Secured special reset, memory blank: full debug enabled.
// - Ones in both error bits of a status register clear them.
// - All ones in a protect register remove protection.
// - Writing one to buffer-empty launches the command.
// - Mass-erase code erases the whole array.
// - Program code programs latched data at latched address.
// - Write-all bit sends writes and launches to every flash block.
// - Configuration zero selects flash block 0.
// - Each block sets complete when its command ends.
// - Flash and EEPROM status share one bit layout.
// - Erase-verify, sector-erase and sector-modify are decoded.
// - Matching key forces live security field unsecured; options byte untouched.
// - Array reads blocked while key access set.
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_security_unsecure #(
  parameter int NUM_BLOCKS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic specialModePin,
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busWord,
  input wire logic busDebug,
  input wire logic [15:0] busWrData,
  output logic [15:0] busRdData,
  output logic busDenied,
  input wire logic [7:0] optionsByte,
  input wire logic [63:0] storedKey,
  input wire logic flashAllErased,
  input wire logic eepromAllErased,
  input wire logic [NUM_BLOCKS-1:0] flashMemDone,
  input wire logic [NUM_BLOCKS-1:0] flashMemBlank,
  input wire logic eepromMemDone,
  input wire logic eepromMemBlank,
  output logic [NUM_BLOCKS-1:0] flashMemStart,
  output logic [7:0] flashMemCode [NUM_BLOCKS],
  output logic [15:0] flashMemAddr [NUM_BLOCKS],
  output logic [15:0] flashMemData [NUM_BLOCKS],
  output logic eepromMemStart,
  output logic [7:0] eepromMemCode,
  output logic [15:0] eepromMemAddr,
  output logic [15:0] eepromMemData,
  output logic [7:0] flashClockDiv,
  output logic [7:0] eepromClockDiv,
  output logic arrayReadEnable,
  output logic secured,
  output logic debugFirmwareEn,
  output logic debugHardwareEn,
  output logic allCommandsDone
);
  localparam int SEL_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

  logic rstMeta, rstN;
  logic modeMeta, specialMode;
  logic [1:0] settle;
  logic [7:0] cfgReg, testMode;
  logic keyAccess, writeAll;
  logic [SEL_W-1:0] blockSel;
  logic [1:0] securityField;
  logic captured;
  nvm_pkg::debug_level_e debugLevel;
  logic [15:0] keyBuf [4];
  logic [3:0] keySeen;
  logic accessOk, wrOk, rdOk, arrayWr, keyWr, cfgWr, keyClose;
  logic [15:0] wrValue, flashAddrValue;
  logic [1:0] fAddrLane, fDataLane, eAddrLane, eDataLane;
  logic fStatWr, fCmdWr, fProtWr, eStatWr, eCmdWr, eProtWr;
  logic [7:0] fStatus [NUM_BLOCKS];
  logic [7:0] fCommand [NUM_BLOCKS];
  logic [7:0] fProtect [NUM_BLOCKS];
  logic [15:0] fAddress [NUM_BLOCKS];
  logic [15:0] flash_data [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0] fDone;
  logic [7:0] eStatus, eProtect;
  logic [15:0] eAddress;
  logic massOnly;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // Mode pin synchronised; capture waits until the strap has settled
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      modeMeta <= 1'b0;
      specialMode <= 1'b0;
      settle <= 2'h0;
    end else if (ce) begin
      modeMeta <= specialModePin;
      specialMode <= modeMeta;
      settle <= {settle[0], 1'b1};
    end
  end

  // 16-bit register: high byte first
  function automatic logic [1:0] lane16(input logic [15:0] a, input logic [15:0] base, input logic word);
    lane16 = {a == base, (word && a == base) || (!word && a == base + 16'h0001)};
  endfunction

  // 8-bit register: byte accesses only
  function automatic logic hit8(input logic [15:0] a, input logic [15:0] base, input logic word);
    hit8 = !word && a == base;
  endfunction

  // Key words match, none all zero or all one
  function automatic logic keyMatch(input logic [63:0] stored, input logic [15:0] w0,
    input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] w3);
    logic [63:0] got;
    logic bad;
    got = {w0, w1, w2, w3};
    bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      bad = bad || got[16*i +: 16] == `KEY_BAD_LOW || got[16*i +: 16] == `KEY_BAD_HIGH;
    end
    keyMatch = !bad && got == stored;
  endfunction

  // Access filter: hardware-only debug still reaches the register space
  always_comb begin
    case (debugLevel)
      nvm_pkg::DBG_FULL: accessOk = 1'b1;
      nvm_pkg::DBG_HW: accessOk = !busDebug || busAddr < `REG_SPACE_END;
      default: accessOk = !busDebug;
    endcase
  end
  assign wrOk = busWrite && accessOk;
  assign rdOk = busRead && accessOk;
  assign wrValue = busWord ? busWrData : {busWrData[7:0], busWrData[7:0]};

  // Array writes: key words or program target
  assign keyWr = wrOk && busWord && keyAccess && busAddr[15:3] == `KEY_BASE >> 3 && !busAddr[0];
  assign arrayWr = wrOk && busWord && !keyAccess && busAddr >= `ARRAY_BASE;
  assign flashAddrValue = arrayWr ? busAddr : wrValue;

  // Register write strobes
  assign cfgWr = wrOk && hit8(busAddr, `OFS_FLASH_CFG, busWord);
  assign fStatWr = wrOk && hit8(busAddr, `OFS_FLASH_STAT, busWord);
  assign fCmdWr = wrOk && hit8(busAddr, `OFS_FLASH_CMD, busWord);
  assign fProtWr = wrOk && hit8(busAddr, `OFS_FLASH_PROT, busWord);
  assign eStatWr = wrOk && hit8(busAddr, `OFS_EE_STAT, busWord);
  assign eCmdWr = wrOk && hit8(busAddr, `OFS_EE_CMD, busWord);
  assign eProtWr = wrOk && hit8(busAddr, `OFS_EE_PROT, busWord);
  assign fAddrLane = arrayWr ? 2'h3 : (wrOk ? lane16(busAddr, `OFS_FLASH_ADDR, busWord) : 2'h0);
  assign fDataLane = arrayWr ? 2'h3 : (wrOk ? lane16(busAddr, `OFS_FLASH_DATA, busWord) : 2'h0);
  assign eAddrLane = wrOk ? lane16(busAddr, `OFS_EE_ADDR, busWord) : 2'h0;
  assign eDataLane = wrOk ? lane16(busAddr, `OFS_EE_DATA, busWord) : 2'h0;

  // Configuration, test mode and clock dividers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfgReg <= 8'h00;
      testMode <= 8'h00;
      flashClockDiv <= 8'h00;
      eepromClockDiv <= 8'h00;
    end else if (ce) begin
      if (cfgWr) cfgReg <= wrValue[7:0];
      if (wrOk && hit8(busAddr, `OFS_FLASH_TEST, busWord)) testMode <= wrValue[7:0];
      if (wrOk && hit8(busAddr, `OFS_FLASH_DIV, busWord)) flashClockDiv <= wrValue[7:0];
      if (wrOk && hit8(busAddr, `OFS_EE_DIV, busWord)) eepromClockDiv <= wrValue[7:0];
    end
  end
  assign keyAccess = cfgReg[`CFG_KEY_BIT];
  assign blockSel = cfgReg[SEL_W-1:0];
  assign writeAll = testMode[`WRITE_ALL_BIT];
  assign arrayReadEnable = !keyAccess;

  // Backdoor key words, collected in key access
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      keySeen <= 4'h0;
      for (int i = 0; i < 4; i++) keyBuf[i] <= 16'h0000;
    end else if (ce) begin
      if (!keyAccess) begin
        keySeen <= 4'h0;
      end else if (keyWr) begin
        keyBuf[busAddr[2:1]] <= busWrData;
        keySeen[busAddr[2:1]] <= 1'b1;
      end
    end
  end

  // Compare on closing key access
  assign keyClose = cfgWr && keyAccess && !wrValue[`CFG_KEY_BIT] && keySeen == 4'hF;

  // Security state caught once the strap is settled
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      captured <= 1'b0;
      securityField <= 2'h0;
      debugLevel <= nvm_pkg::DBG_OFF;
    end else if (ce) begin
      if (!captured && settle[1]) begin
        captured <= 1'b1;
        securityField <= optionsByte[1:0];
        if (optionsByte[1:0] == `SEC_UNSECURED) begin
          debugLevel <= nvm_pkg::DBG_FULL;
        end else if (specialMode) begin
          // Blank part: full debug, else hardware only
          debugLevel <= (flashAllErased && eepromAllErased) ? nvm_pkg::DBG_FULL : nvm_pkg::DBG_HW;
        end else begin
          debugLevel <= nvm_pkg::DBG_OFF;
        end
      end else if (captured && keyClose && !specialMode && secured && optionsByte[7:6] == `KEYEN_ON) begin
        // Options byte untouched; security returns at next reset
        if (keyMatch(storedKey, keyBuf[0], keyBuf[1], keyBuf[2], keyBuf[3])) begin
          securityField <= `SEC_UNSECURED;
          debugLevel <= nvm_pkg::DBG_FULL;
        end
      end
    end
  end
  assign secured = !captured || securityField != `SEC_UNSECURED;
  assign debugFirmwareEn = debugLevel == nvm_pkg::DBG_FULL;
  assign debugHardwareEn = debugLevel != nvm_pkg::DBG_OFF;
  assign massOnly = secured && specialMode && debugLevel != nvm_pkg::DBG_FULL;

  // One engine per block; write-all fans out
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : gBlock
    logic en;
    assign en = writeAll || blockSel == SEL_W'(b);
    nvm_cmd_engine uEngine (
      .clk(clk),
      .rstN(rstN),
      .ce(ce),
      .massOnly(massOnly),
      .wrValue(wrValue),
      .addrValue(flashAddrValue),
      .wrStatus(en && fStatWr),
      .wrCommand(en && fCmdWr),
      .wrProtect(en && fProtWr),
      .wrAddrLane(en ? fAddrLane : 2'h0),
      .wrDataLane(en ? fDataLane : 2'h0),
      .memDone(flashMemDone[b]),
      .memBlank(flashMemBlank[b]),
      .status(fStatus[b]),
      .command(fCommand[b]),
      .protect(fProtect[b]),
      .address(fAddress[b]),
      .data(flash_data[b]),
      .memStart(flashMemStart[b]),
      .memAddr(flashMemAddr[b])
    );
    assign flashMemCode[b] = fCommand[b];
    assign flashMemData[b] = flash_data[b];
    assign fDone[b] = fStatus[b][`BIT_DONE];
  end

  // EEPROM engine
  nvm_cmd_engine uEeprom (
    .clk(clk),
    .rstN(rstN),
    .ce(ce),
    .massOnly(massOnly),
    .wrValue(wrValue),
    .addrValue(wrValue),
    .wrStatus(eStatWr),
    .wrCommand(eCmdWr),
    .wrProtect(eProtWr),
    .wrAddrLane(eAddrLane),
    .wrDataLane(eDataLane),
    .memDone(eepromMemDone),
    .memBlank(eepromMemBlank),
    .status(eStatus),
    .command(eepromMemCode),
    .protect(eProtect),
    .address(eAddress),
    .data(eepromMemData),
    .memStart(eepromMemStart),
    .memAddr(eepromMemAddr)
  );

  // Software waits on this before resetting
  assign allCommandsDone = (&fDone) && eStatus[`BIT_DONE];

  // Read decode; banked registers show the selected block
  function automatic logic [7:0] readByte(input logic [15:0] a);
    readByte = 8'h00;
    case (a)
      `OFS_FLASH_DIV: readByte = flashClockDiv;
      `OFS_FLASH_SEC: readByte = {optionsByte[7:2], securityField};
      `OFS_FLASH_TEST: readByte = testMode;
      `OFS_FLASH_CFG: readByte = cfgReg;
      `OFS_FLASH_PROT: readByte = fProtect[blockSel];
      `OFS_FLASH_STAT: readByte = fStatus[blockSel];
      `OFS_FLASH_CMD: readByte = fCommand[blockSel];
      `OFS_FLASH_ADDR: readByte = fAddress[blockSel][15:8];
      `OFS_FLASH_ADDR + 16'h0001: readByte = fAddress[blockSel][7:0];
      `OFS_FLASH_DATA: readByte = flash_data[blockSel][15:8];
      `OFS_FLASH_DATA + 16'h0001: readByte = flash_data[blockSel][7:0];
      `OFS_EE_DIV: readByte = eepromClockDiv;
      `OFS_EE_PROT: readByte = eProtect;
      `OFS_EE_STAT: readByte = eStatus;
      `OFS_EE_CMD: readByte = eepromMemCode;
      `OFS_EE_ADDR: readByte = eAddress[15:8];
      `OFS_EE_ADDR + 16'h0001: readByte = eAddress[7:0];
      `OFS_EE_DATA: readByte = eepromMemData[15:8];
      `OFS_EE_DATA + 16'h0001: readByte = eepromMemData[7:0];
      default: readByte = 8'h00;
    endcase
  endfunction

  // Read data one cycle after strobe
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busRdData <= 16'h0000;
      busDenied <= 1'b0;
    end else if (ce) begin
      busDenied <= (busRead || busWrite) && !accessOk;
      if (rdOk) begin
        busRdData <= busWord ? {readByte(busAddr), readByte(busAddr + 16'h0001)} : {8'h00, readByte(busAddr)};
      end
    end
  end
endmodule // nvm_security_unsecure

// *** nvm_security_unsecure_checker.sv ***
// Port assertions for the NVM security block
`timescale 1ns/1ps
module nvm_security_unsecure_checker #(
  parameter int NUM_BLOCKS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busWord,
  input wire logic busDebug,
  input wire logic [15:0] busWrData,
  input wire logic busDenied,
  input wire logic [NUM_BLOCKS-1:0] flashMemStart,
  input wire logic eepromMemStart,
  input wire logic arrayReadEnable,
  input wire logic secured,
  input wire logic debugFirmwareEn,
  input wire logic debugHardwareEn,
  input wire logic allCommandsDone
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // EEPROM launch
  sequence eeLaunch;
    ce && busWrite && !busWord && busAddr == 16'h0115 && busWrData[7];
  endsequence
  // CPU key access on
  sequence keyOn;
    ce && busWrite && !busWord && !busDebug && busAddr == 16'h0103 && busWrData[5];
  endsequence
  // Debug access, port shut
  sequence dbgShut;
    ce && busDebug && (busRead || busWrite) && !debugHardwareEn;
  endsequence
  ee_start_pulse_a: assert property ($rose(eepromMemStart) |=> !eepromMemStart)
    else $error("Start too wide");
  ee_start_cause_a: assert property (eepromMemStart |->
    $past(ce && busWrite && busAddr[15:1] == 15'h008A && busWrData[7]))
    else $error("EE start unexplained");
  fl_start_cause_a: assert property (|flashMemStart |->
    $past(ce && busWrite && busAddr[15:1] == 15'h0082 && busWrData[7]))
    else $error("Flash start unexplained");
  busy_clears_done_a: assert property (eeLaunch ##1 eepromMemStart |-> !allCommandsDone)
    else $error("Done while busy");
  key_blocks_read_a: assert property (keyOn |=> !arrayReadEnable)
    else $error("Array reads open during key access");
  deny_cause_a: assert property (busDenied |-> $past(ce && busDebug && (busRead || busWrite)))
    else $error("Denial without debug access");
  shut_port_deny_a: assert property (dbgShut |=> busDenied)
    else $error("Debug access passed while shut");
  hw_range_deny_a: assert property (ce && busDebug && busRead && debugHardwareEn && !debugFirmwareEn
    && busAddr >= 16'h0400 |=> busDenied)
    else $error("HW debug out of range");
  reset_secured_a: assert property ($rose(arst_n) |-> secured)
    else $error("Part unsecured during reset");
endmodule // nvm_security_unsecure_checker

bind nvm_security_unsecure nvm_security_unsecure_checker #(.NUM_BLOCKS(NUM_BLOCKS)) i_chk (
  .clk(clk), .arst_n(arst_n), .ce(ce), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
  .busWord(busWord), .busDebug(busDebug), .busWrData(busWrData), .busDenied(busDenied),
  .flashMemStart(flashMemStart), .eepromMemStart(eepromMemStart), .arrayReadEnable(arrayReadEnable),
  .secured(secured), .debugFirmwareEn(debugFirmwareEn), .debugHardwareEn(debugHardwareEn),
  .allCommandsDone(allCommandsDone));

// *** nvm_security_unsecure_tb.sv ***
// Self-checking bench for the NVM security block
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_security_unsecure_tb;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic ce = 1'h1;
  logic specialModePin = 1'h0;
  logic busWrite = 1'h0;
  logic busRead = 1'h0;
  logic busWord = 1'h0;
  logic busDebug = 1'h0;
  logic [15:0] busAddr = 16'h0000;
  logic [15:0] busWrData = 16'h0000;
  logic [7:0] optionsByte = 8'h80;
  logic [63:0] storedKey = 64'h1234_5678_9ABC_DEF1;
  logic flashAllErased = 1'h0;
  logic eepromAllErased = 1'h0;
  logic [3:0] flashMemDone = 4'h0;
  logic eepromMemDone = 1'h0;
  logic eepromMemBlank = 1'h0;
  logic [15:0] busRdData;
  logic busDenied, eepromMemStart, arrayReadEnable, secured;
  logic debugFirmwareEn, debugHardwareEn, allCommandsDone, den;
  logic [3:0] flashMemStart;
  logic [7:0] flashMemCode [4];
  logic [15:0] flashMemAddr [4];
  logic [15:0] flashMemData [4];
  logic [7:0] eepromMemCode;
  logic [7:0] codes [5] = '{`CMD_ERASE_VERIFY, `CMD_PROGRAM, `CMD_SECTOR_ERASE, `CMD_MASS_ERASE, `CMD_SECTOR_MODIFY};
  int errorCnt = 0;
  int checksDone = 0;

  nvm_security_unsecure #(.NUM_BLOCKS(4)) i_nvm_security_unsecure (
    .clk, .arst_n, .ce, .specialModePin, .busAddr, .busWrite, .busRead, .busWord, .busDebug,
    .busWrData, .busRdData, .busDenied, .optionsByte, .storedKey, .flashAllErased,
    .eepromAllErased, .flashMemDone, .flashMemBlank(4'h0), .eepromMemDone, .eepromMemBlank,
    .flashMemStart, .flashMemCode, .flashMemAddr, .flashMemData, .eepromMemStart,
    .eepromMemCode, .eepromMemAddr(), .eepromMemData(), .flashClockDiv(), .eepromClockDiv(),
    .arrayReadEnable, .secured, .debugFirmwareEn, .debugHardwareEn, .allCommandsDone);

  // 200 MHz clock
  initial forever #2.5 clk = ~clk;

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checksDone++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask

  // Single write
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w = 1'h0, input logic g = 1'h0);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWord <= w;
    busDebug <= g;
    busWrite <= 1'h1;
    @(posedge clk);
    busWrite <= 1'h0;
    #1;
  endtask

  // Byte read and check
  task automatic rd(input logic [15:0] a, input logic g, input logic [15:0] exp, input logic eDen, input string msg);
    @(posedge clk);
    busAddr <= a;
    busWord <= 1'h0;
    busDebug <= g;
    busRead <= 1'h1;
    @(posedge clk);
    busRead <= 1'h0;
    #1;
    den = busDenied;
    @(posedge clk);
    #1;
    chk(16'(den), 16'(eDen), msg);
    if (!eDen) chk(busRdData, exp, msg);
  endtask

  // Load code and launch
  task automatic go(input logic [15:0] stat, input logic [7:0] c);
    wr(stat + 16'h0001, {8'h00, c});
    wr(stat, 16'h0080);
  endtask

  // Array completion
  task automatic fin(input logic [3:0] f, input logic e, input logic b);
    @(posedge clk);
    flashMemDone <= f;
    eepromMemDone <= e;
    eepromMemBlank <= b;
    @(posedge clk);
    flashMemDone <= 4'h0;
    eepromMemDone <= 1'h0;
    eepromMemBlank <= 1'h0;
    @(posedge clk);
    #1;
  endtask

  // Reset with strap, blank flags and options
  task automatic doReset(input logic sp, input logic er, input logic [7:0] ob);
    @(posedge clk);
    specialModePin <= sp;
    flashAllErased <= er;
    eepromAllErased <= er;
    optionsByte <= ob;
    arst_n <= 1'h0;
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Backdoor sequence
  task automatic keys(input logic [63:0] k);
    wr(16'h0103, 16'h0020);
    chk(16'(arrayReadEnable), 16'h0, "key read block");
    for (int i = 0; i < 4; i++) wr(16'hFF00 + 16'(2 * i), k[63 - 16 * i -: 16], 1'h1);
    wr(16'h0103, 16'h0000);
  endtask

  task automatic tReset;
    rd(16'h0115, 1'h0, 16'h00C0, 1'h0, "ee stat");
    rd(16'h0105, 1'h0, 16'h00C0, 1'h0, "fl stat");
    rd(16'h0104, 1'h0, 16'h0000, 1'h0, "fl prot");
    chk(16'(allCommandsDone), 16'h1, "all done");
    rd(16'h0115, 1'h1, 16'h0000, 1'h1, "dbg shut");
  endtask

  // Protection, stale error, program
  task automatic tProt;
    wr(16'h0103, 16'h0000);
    wr(16'hFF0E, 16'hFFBE, 1'h1);
    go(16'h0105, 8'h20);
    chk(16'(flashMemStart), 16'h0, "prot start");
    rd(16'h0105, 1'h0, 16'h00E0, 1'h0, "pviol");
    go(16'h0105, 8'h20);
    rd(16'h0105, 1'h0, 16'h00F0, 1'h0, "accerr");
    wr(16'h0105, 16'h0030);
    rd(16'h0105, 1'h0, 16'h00C0, 1'h0, "cleared");
    wr(16'h0104, 16'h00FF);
    go(16'h0105, 8'h20);
    chk(16'(flashMemStart), 16'h1, "blk0 start");
    chk(flashMemAddr[0], 16'hFF0E, "prog addr");
    chk(flashMemData[0], 16'hFFBE, "prog data");
    fin(4'h1, 1'h0, 1'h0);
    rd(16'h0105, 1'h0, 16'h00C0, 1'h0, "prog end");
  endtask

  // Broadcast mass erase
  task automatic tAll;
    wr(16'h0102, 16'h0010);
    wr(16'h0104, 16'h00FF);
    wr(16'h0105, 16'h0030);
    wr(16'h010A, 16'h0000, 1'h1);
    wr(16'h0108, 16'h0000, 1'h1);
    go(16'h0105, 8'h41);
    chk(16'(flashMemStart), 16'hF, "all start");
    for (int b = 0; b < 4; b++) chk(16'(flashMemCode[b]), 16'h0041, "all code");
    fin(4'h7, 1'h0, 1'h0);
    chk(16'(allCommandsDone), 16'h0, "part done");
    fin(4'h8, 1'h0, 1'h0);
    chk(16'(allCommandsDone), 16'h1, "all done");
    wr(16'h0102, 16'h0000);
  endtask

  // EEPROM codes
  task automatic tEe;
    wr(16'h0114, 16'h00FF);
    wr(16'h0115, 16'h0030);
    wr(16'h011A, 16'h0000, 1'h1);
    wr(16'h0118, 16'h0000, 1'h1);
    foreach (codes[i]) begin
      go(16'h0115, codes[i]);
      chk(16'(eepromMemStart), 16'h1, "ee start");
      chk(16'(eepromMemCode), 16'(codes[i]), "ee code");
      rd(16'h0115, 1'h0, 16'h0000, 1'h0, "ee busy");
      fin(4'h0, 1'h1, codes[i] == 8'h05);
      rd(16'h0115, 1'h0, (codes[i] == 8'h05) ? 16'h00C4 : 16'h00C0, 1'h0, "ee end");
    end
    go(16'h0115, 8'h33);
    rd(16'h0115, 1'h0, 16'h00D0, 1'h0, "bad code");
    wr(16'h0115, 16'h0030);
  endtask

  // Backdoor keys and security at reset
  task automatic tKey;
    keys(64'h1234_5678_9ABC_DEF0);
    repeat (10) @(posedge clk);
    #1;
    chk(16'(secured), 16'h1, "bad key");
    keys(storedKey);
    for (int n = 0; n < 10 && secured; n++) @(posedge clk);
    #1;
    chk(16'(secured), 16'h0, "good key");
    chk(16'(debugFirmwareEn), 16'h1, "key debug");
    chk(16'(arrayReadEnable), 16'h1, "reads back");
    doReset(1'h0, 1'h0, 8'h80);
    chk(16'(secured), 16'h1, "reverts");
    @(posedge clk);
    optionsByte <= 8'h82;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(secured), 16'h1, "not yet");
    doReset(1'h0, 1'h0, 8'h82);
    chk(16'(secured), 16'h0, "next reset");
  endtask

  // Special-mode resets
  task automatic tSpecial;
    doReset(1'h1, 1'h0, 8'h80);
    chk(16'(debugHardwareEn), 16'h1, "hw debug");
    chk(16'(debugFirmwareEn), 16'h0, "no fw debug");
    rd(16'h4000, 1'h1, 16'h0000, 1'h1, "dbg array");
    wr(16'h0114, 16'h00FF, 1'h0, 1'h1);
    rd(16'h0114, 1'h1, 16'h00FF, 1'h0, "dbg prot");
    doReset(1'h1, 1'h1, 8'hFF);
    chk(16'(debugFirmwareEn), 16'h1, "fw debug");
  endtask

  // Verdict and end of run
  task automatic wrapUp;
    if (errorCnt == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    tReset;
    tProt;
    tAll;
    tEe;
    tKey;
    tSpecial;
    wrapUp;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    wrapUp();
  end
endmodule // nvm_security_unsecure_tb
